// *** src/axil_regs.v ***
// axi4-lite slave holding the four channel control registers
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`include "event_router_defs.vh"

module axil_regs (
    // clock and reset
    input  wire        core_clk,
    input  wire        srst,
    // write address, data and response
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // read
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // register contents and status
    output wire [127:0] ctrl_flat,
    input  wire [31:0]  status_word
);

    reg  [31:0] ctrl_r [0:3];
    reg  [7:0]  waddr_r;
    reg  [31:0] wdata_r;
    reg  [3:0]  wstrb_r;
    reg         have_aw_r;
    reg         have_w_r;
    integer     k;

    function [2:0] decode;
        input [7:0] addr;
        begin
            case (addr)
                `CTRL_OFFSET_0: decode = 3'h0;
                `CTRL_OFFSET_1: decode = 3'h1;
                `CTRL_OFFSET_2: decode = 3'h2;
                `CTRL_OFFSET_3: decode = 3'h3;
                `STATUS_OFFSET: decode = 3'h4;
                default:        decode = 3'h7;
            endcase
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_flat
            assign ctrl_flat[g*32 +: 32] = ctrl_r[g];
        end
    endgenerate

    wire       aw_take = s_axi_awvalid & s_axi_awready;
    wire       w_take  = s_axi_wvalid & s_axi_wready;
    wire       aw_now  = have_aw_r | aw_take;
    wire       w_now   = have_w_r | w_take;
    wire [7:0] wa      = have_aw_r ? waddr_r : s_axi_awaddr;
    wire [31:0] wd     = have_w_r ? wdata_r : s_axi_wdata;
    wire [3:0] ws      = have_w_r ? wstrb_r : s_axi_wstrb;
    wire       do_wr   = aw_now & w_now & ~s_axi_bvalid;
    wire [2:0] widx    = decode(wa);
    wire [2:0] ridx    = decode(s_axi_araddr);
    wire [31:0] bmask  = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}}
                         & `CTRL_WRITE_MASK;

    always @(posedge core_clk) begin
        if (srst) begin
            for (k = 0; k < 4; k = k + 1)
                ctrl_r[k] <= `CTRL_RESET;
            have_aw_r     <= 1'b0;
            have_w_r      <= 1'b0;
            waddr_r       <= 8'h00;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AXI_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `AXI_RESP_OKAY;
        end else begin
            // hold each channel once taken until the write completes
            if (aw_take && !do_wr) begin
                have_aw_r <= 1'b1;
                waddr_r   <= s_axi_awaddr;
            end
            if (w_take && !do_wr) begin
                have_w_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            s_axi_awready <= ~aw_now & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready  <= ~w_now & ~s_axi_wready & ~s_axi_bvalid;
            if (do_wr) begin
                have_aw_r    <= 1'b0;
                have_w_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (widx < 3'h4) begin
                    ctrl_r[widx[1:0]] <= (ctrl_r[widx[1:0]] & ~bmask)
                                         | (wd & bmask);
                    s_axi_bresp <= `AXI_RESP_OKAY;
                end else if (widx == 3'h4) begin
                    s_axi_bresp <= `AXI_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `AXI_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // read: arready one cycle, data the next
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `AXI_RESP_OKAY;
                if (ridx < 3'h4)
                    s_axi_rdata <= ctrl_r[ridx[1:0]];
                else if (ridx == 3'h4)
                    s_axi_rdata <= status_word;
                else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `AXI_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// *** src/event_router_defs.vh ***
// register offsets, field positions and reset values of the event router
`ifndef EVENT_ROUTER_DEFS_VH
`define EVENT_ROUTER_DEFS_VH

`define CTRL_OFFSET_0        8'h00
`define CTRL_OFFSET_1        8'h04
`define CTRL_OFFSET_2        8'h08
`define CTRL_OFFSET_3        8'h0c
`define STATUS_OFFSET        8'h10
`define EVEN_SEL_HI          14
`define EVEN_SEL_LO          12
`define EVEN_EN_BIT          11
`define ODD_SEL_HI           30
`define ODD_SEL_LO           28
`define ODD_EN_BIT           27
`define CTRL_WRITE_MASK      32'h7800_7800
`define CTRL_RESET           32'h0000_0000
`define SEL_HIGH_GROUP_BIT   2
`define AXI_RESP_OKAY        2'b00
`define AXI_RESP_SLVERR      2'b10

`endif

// *** src/route_decode.v ***
// decoder of one selector into one-hot gating unit lines
`include "event_router_defs.vh"

module route_decode #(
    parameter UNITS = 8
) (
    // selector
    input  wire [2:0]       sel,
    input  wire             enable,
    input  wire             event_in,
    // routed lines
    output wire [UNITS-1:0] lines
);

    genvar u;
    generate
        for (u = 0; u < UNITS; u = u + 1) begin : g_unit
            // only codes 100 to 111 reach units 4 to 7; lower codes unused
            assign lines[u] = event_in & enable
                & sel[`SEL_HIGH_GROUP_BIT]
                & (u >= 4) & (sel[1:0] == (u % 4));
        end
    endgenerate

endmodule

// *** src/event_input_destination_router.v ***
// top of the event router: registers and routed trigger lines
`include "event_router_defs.vh"

// Contract
// - selector bits 14:12 pick the unit for even event, when enabled
// - even codes 100 to 111 send channel 2i to units 4 to 7
// - selector bits 30:28 pick the unit for odd event, when enabled
// - odd codes 100 to 111 send channel 2i+1 to units 4 to 7
// - each routed line indexed by source channel and unit index
// - four control registers, register i serves channels 2i and 2i+1
module event_input_destination_router #(
    parameter CHANNELS = 8,
    parameter UNITS    = 8
) (
    // clock and reset
    input  wire                      core_clk,
    input  wire                      srst,
    // axi4-lite write
    input  wire [7:0]                s_axi_awaddr,
    input  wire                      s_axi_awvalid,
    output wire                      s_axi_awready,
    input  wire [31:0]               s_axi_wdata,
    input  wire [3:0]                s_axi_wstrb,
    input  wire                      s_axi_wvalid,
    output wire                      s_axi_wready,
    output wire [1:0]                s_axi_bresp,
    output wire                      s_axi_bvalid,
    input  wire                      s_axi_bready,
    // axi4-lite read
    input  wire [7:0]                s_axi_araddr,
    input  wire                      s_axi_arvalid,
    output wire                      s_axi_arready,
    output wire [31:0]               s_axi_rdata,
    output wire [1:0]                s_axi_rresp,
    output wire                      s_axi_rvalid,
    input  wire                      s_axi_rready,
    // input channel events
    input  wire [CHANNELS-1:0]       edge_trigger_input_channel,
    // routed lines, bit c*UNITS+u is channel c to unit u
    output reg  [CHANNELS*UNITS-1:0] routed_trigger_line,
    // per-unit merged trigger
    output reg  [UNITS-1:0]          output_gating_unit
);

    wire [127:0]              ctrl_flat;
    wire [CHANNELS*UNITS-1:0] lines;
    reg  [UNITS-1:0]          merged;
    reg  [31:0]               status_r;
    integer                   c;

    axil_regs u_regs (
        .core_clk      (core_clk),
        .srst          (srst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .ctrl_flat     (ctrl_flat),
        .status_word   (status_r)
    );

    genvar i;
    generate
        // register i serves channels 2i and 2i+1
        // pair per register
        for (i = 0; i < CHANNELS / 2; i = i + 1) begin : g_pair
            wire [31:0] ctrl = ctrl_flat[i*32 +: 32];
            route_decode #(.UNITS(UNITS)) u_even (
                .sel      (ctrl[`EVEN_SEL_HI:`EVEN_SEL_LO]),
                .enable   (ctrl[`EVEN_EN_BIT]),
                .event_in (edge_trigger_input_channel[2*i]),
                .lines    (lines[(2*i)*UNITS +: UNITS])
            );
            route_decode #(.UNITS(UNITS)) u_odd (
                .sel      (ctrl[`ODD_SEL_HI:`ODD_SEL_LO]),
                .enable   (ctrl[`ODD_EN_BIT]),
                .event_in (edge_trigger_input_channel[2*i+1]),
                .lines    (lines[(2*i+1)*UNITS +: UNITS])
            );
        end
    endgenerate

    always @* begin
        merged = {UNITS{1'b0}};
        for (c = 0; c < CHANNELS; c = c + 1)
            merged = merged | lines[c*UNITS +: UNITS];
    end

    // registered outputs cost one cycle of latency but keep glitches off
    always @(posedge core_clk) begin
        if (srst) begin
            routed_trigger_line <= {CHANNELS*UNITS{1'b0}};
            output_gating_unit  <= {UNITS{1'b0}};
            status_r            <= 32'h0000_0000;
        end else begin
            routed_trigger_line <= lines;
            output_gating_unit  <= merged;
            status_r            <= {{(32-UNITS-CHANNELS){1'b0}},
                                    merged, edge_trigger_input_channel};
        end
    end

endmodule

// *** verification/event_router_monitor.sv ***
// port-level assertions for the event router
module event_router_monitor (
    // clock and reset
    input logic        core_clk,
    input logic        srst,
    // register bus answers
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    // events and routed lines
    input logic [7:0]  edge_trigger_input_channel,
    input logic [63:0] routed_trigger_line,
    input logic [7:0]  output_gating_unit
);
    logic [7:0] ch_any;
    logic [7:0] unit_or;
    logic       multi;
    // per-channel summaries keep the properties short
    always_comb begin
        ch_any = 8'h00;
        unit_or = 8'h00;
        multi = 1'b0;
        for (int c = 0; c < 8; c++) begin
            ch_any[c] = |routed_trigger_line[c*8 +: 8];
            unit_or = unit_or | routed_trigger_line[c*8 +: 8];
            multi = multi | !$onehot0(routed_trigger_line[c*8 +: 8]);
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    chk_low_units_idle: assert property (
        (routed_trigger_line & 64'h0f0f_0f0f_0f0f_0f0f) == 64'h0)
        else $error("line routed to a unit below four");
    chk_route_cause: assert property (
        (ch_any & ~$past(edge_trigger_input_channel)) == 8'h00)
        else $error("routed line without a prior input event");
    chk_unit_merge: assert property (
        output_gating_unit == unit_or)
        else $error("unit output differs from its routed lines");
    chk_single_dest: assert property (!multi)
        else $error("one channel routed to two units");
    chk_reset_quiet: assert property (
        $past(srst) |-> routed_trigger_line == 64'h0
            && output_gating_unit == 8'h00)
        else $error("outputs active right after reset");
    chk_idle_follow: assert property (
        edge_trigger_input_channel == 8'h00 |=> routed_trigger_line == 64'h0)
        else $error("routed line with no input event");
    chk_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    chk_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
            && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer changed before taken");
endmodule

bind event_input_destination_router event_router_monitor i_mon (
    .core_clk(core_clk), .srst(srst), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .edge_trigger_input_channel(edge_trigger_input_channel),
    .routed_trigger_line(routed_trigger_line),
    .output_gating_unit(output_gating_unit));

// *** verification/tb_top.sv ***
// self-checking bench for the event router
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [7:0]  edge_trigger_input_channel = 8'h00;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire         s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [63:0] routed_trigger_line;
    wire  [7:0]  output_gating_unit;
    logic [31:0] cfg [4];
    logic [31:0] rd;
    logic [1:0]  rsp;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    event_input_destination_router i_dut (.core_clk, .srst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .edge_trigger_input_channel, .routed_trigger_line,
        .output_gating_unit);

    always #50 core_clk = ~core_clk;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // aw and w offered together, each released once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge core_clk);
            if (s_axi_awready === 1'b1 && !aw_ok) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1 && !w_ok) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        // one idle edge so back-to-back calls never drive bready twice
        @(posedge core_clk);
    endtask

    task automatic axi_read(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        // one idle edge so back-to-back calls never drive rready twice
        @(posedge core_clk);
    endtask

    task automatic set_cfg(input int i, input logic [31:0] d);
        cfg[i] = d;
        axi_write(8'(i * 4), d);
        check(rsp, 2'b00);
        axi_read(8'(i * 4));
        check(rd, d & 32'h7800_7800);
    endtask

    // expected lines worked out from the shadow copy of the registers
    task automatic pulse(input logic [7:0] pat);
        logic [63:0] el;
        logic [7:0]  eu;
        logic [2:0]  sel;
        logic        en;
        el = 64'h0;
        eu = 8'h00;
        for (int c = 0; c < 8; c++) begin
            sel = c[0] ? cfg[c/2][30:28] : cfg[c/2][14:12];
            en = c[0] ? cfg[c/2][27] : cfg[c/2][11];
            if (pat[c] && en && sel[2]) begin
                el[c*8+sel] = 1'b1;
                eu[sel] = 1'b1;
            end
        end
        edge_trigger_input_channel <= pat;
        @(posedge core_clk);
        edge_trigger_input_channel <= 8'h00;
        #1;
        check(routed_trigger_line, el);
        check(output_gating_unit, eu);
        @(posedge core_clk);
    endtask

    task automatic t_regs();
        for (int i = 0; i < 4; i++) begin
            axi_read(8'(i * 4));
            check(rd, 32'h0);
        end
        set_cfg(0, 32'hffff_ffff);
        // byte lane 1 only: the even half clears, the odd half stays
        s_axi_wstrb <= 4'h2;
        axi_write(8'h00, 32'h0);
        check(rsp, 2'b00);
        s_axi_wstrb <= 4'hf;
        axi_read(8'h00);
        check(rd, 32'h7800_0000);
        // status ignores writes and shows the units and the inputs
        edge_trigger_input_channel <= 8'h02;
        axi_write(8'h10, 32'hffff_ffff);
        check(rsp, 2'b00);
        axi_read(8'h10);
        check({rsp, rd}, {2'b00, 32'h0000_8002});
        edge_trigger_input_channel <= 8'h00;
        axi_write(8'h40, 32'hffff_ffff);
        check(rsp, 2'b10);
        axi_read(8'h40);
        check({rsp, rd}, {2'b10, 32'h0});
    endtask

    // every upper code on both selectors of all four registers
    task automatic t_route();
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 4; i++)
                set_cfg(i, {1'b0, 3'(7 - k), 1'b1, 12'h000,
                            3'(4 + k), 1'b1, 11'h000});
            pulse(8'hff);
            pulse(8'h55);
            pulse(8'haa);
        end
    endtask

    // enables clear, then enabled low codes: nothing routes
    task automatic t_disabled();
        for (int i = 0; i < 4; i++)
            set_cfg(i, 32'h7000_7000);
        pulse(8'hff);
        for (int i = 0; i < 4; i++)
            set_cfg(i, 32'h3800_3800);
        pulse(8'hff);
    endtask

    task automatic close_out();
        $display("errors %0d, compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // the whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            close_out();
        end
    end

    initial begin
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        t_regs();
        t_route();
        t_disabled();
        close_out();
    end
endmodule
